// >>> hw/sas_sequencer.sv
/*
  Sequencer for an 8-bit SAR converter: control/status and result registers,
  multiplexer select, sample switch, trial code and comparator sampling.
  Assumes the analog side settles the comparator within one sys_clk.
*/
`timescale 1ns/1ps
module sas_sequencer import sas_pkg::*; #(
    parameter int CHANNELS = 16
) (
    input wire logic sys_clk,          // 40 MHz CPU clock
    input wire logic reset,            // Synchronous, active high
    input wire logic csr_wr,           // Control/status write strobe
    input wire logic [7:0] csr_wdata,  // Control/status write data
    input wire logic result_rd,        // Result register read strobe
    input wire logic comp_high,        // Comparator: input at or above trial level
    output logic [7:0] csr_rdata,      // Control/status read value
    output logic [7:0] result_register,// Last completed code
    output logic [3:0] mux_select,     // Analog multiplexer channel
    output logic sample_connect,       // Sample capacitor to input pin
    output logic [7:0] trial_code,     // Code driven to the comparison DAC
    output logic converter_power       // Analog power enable
);
    // -----------------------------------------------------------------
    // Control bits
    // -----------------------------------------------------------------
    logic converter_on;
    logic [3:0] channel_select;
    logic conversion_done_flag;
    logic phase;
    logic [3:0] step;
    logic [7:0] code;
    sas_state_t state;
    sas_state_t next_state;
    logic conv_tick;
    logic restart;
    logic finish;
    logic load_end;
    logic [2:0] decide_bit;
    logic [7:0] next_code;

    assign conv_tick = phase;
    // A write with the on bit set aborts the running conversion and starts anew
    assign restart = csr_wr && csr_wdata[CSR_ON_BIT];
    // Last approximation tick of a conversion that is still switched on
    assign finish = converter_on && conv_tick && state == SAS_APPROX && step == APPROX_LAST;
    assign load_end = conv_tick && state == SAS_LOAD && step == LOAD_LAST;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            converter_on <= CSR_RESET[CSR_ON_BIT];
        end else if (csr_wr) begin
            converter_on <= csr_wdata[CSR_ON_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            channel_select <= CSR_RESET[CSR_CH_LSB +: CSR_CH_W];
        end else if (csr_wr) begin
            channel_select <= csr_wdata[CSR_CH_LSB +: CSR_CH_W];
        end
    end

    // -----------------------------------------------------------------
    // Conversion-done flag
    // -----------------------------------------------------------------
    // Set wins over clear; a restarting write suppresses the set
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            conversion_done_flag <= CSR_RESET[CSR_DONE_BIT];
        end else if (finish && !restart) begin
            conversion_done_flag <= 1'b1;
        end else if (csr_wr || result_rd) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Converter clock: sys_clk divided by two
    // -----------------------------------------------------------------
    // Cleared by a restart so every conversion starts on the same phase
    always_ff @(posedge sys_clk) begin
        if (reset || restart || !converter_on) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end

    // -----------------------------------------------------------------
    // Sequencer state
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= SAS_OFF;
        end else if (restart) begin
            state <= SAS_LOAD;
        end else if (!converter_on) begin
            state <= SAS_OFF;
        end else if (conv_tick) begin
            state <= next_state;
        end
    end

    // Phase changes other than restart and switch-off are applied only on converter ticks
    always_comb begin
        next_state = state;
        case (state)
            SAS_OFF: begin
                next_state = SAS_LOAD;
            end
            SAS_LOAD: begin
                if (step == LOAD_LAST) begin
                    next_state = SAS_APPROX;
                end
            end
            SAS_APPROX: begin
                if (step == APPROX_LAST) begin
                    next_state = SAS_LOAD;
                end
            end
            default: begin
                next_state = SAS_OFF;
            end
        endcase
    end

    // Step counts converter ticks within the current phase
    always_ff @(posedge sys_clk) begin
        if (reset || restart || !converter_on) begin
            step <= 4'h0;
        end else if (conv_tick) begin
            if (next_state != state) begin
                step <= 4'h0;
            end else begin
                step <= step + 4'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Trial code, decided MSB first
    // -----------------------------------------------------------------
    // Bit under test walks from 7 down to 0
    assign decide_bit = 3'(APPROX_LAST - step);
    for (genvar i = 0; i < 8; i++) begin : g_code_bit
        // Keep the tested bit if the comparator agrees, then try the bit below
        assign next_code[i] = (decide_bit == 3'(i)) ? (code[i] & comp_high) :
            (step != APPROX_LAST && decide_bit == 3'(i + 1)) ? 1'b1 : code[i];
    end

    always_ff @(posedge sys_clk) begin
        if (reset || restart || !converter_on) begin
            code <= TRIAL_START;
        end else if (load_end) begin
            code <= TRIAL_START;
        end else if (conv_tick && state == SAS_APPROX) begin
            code <= next_code;
        end
    end

    // -----------------------------------------------------------------
    // Result register
    // -----------------------------------------------------------------
    // Final code: all kept bits, last decided by comparator (FFh/00h at rails)
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            result_register <= RESULT_RESET;
        end else if (finish && !restart) begin
            result_register <= {code[7:1], comp_high};
        end
    end

    // -----------------------------------------------------------------
    // Analog-facing outputs, registered
    // -----------------------------------------------------------------
    // Channel numbers beyond the fitted inputs fall back to input 0
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mux_select <= 4'h0;
        end else begin
            mux_select <= (32'(channel_select) < CHANNELS) ? channel_select : 4'h0;
        end
    end

    // Switch opens during approximation and stays open when off
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sample_connect <= 1'b0;
        end else begin
            sample_connect <= converter_on && !restart && state == SAS_LOAD;
        end
    end

    // One sys_clk behind the internal code; the analog side settles in that time
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trial_code <= 8'h00;
        end else begin
            trial_code <= code;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            converter_power <= 1'b0;
        end else begin
            converter_power <= converter_on;
        end
    end

    // -----------------------------------------------------------------
    // Control/status read-back
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            csr_rdata <= CSR_RESET;
        end else begin
            csr_rdata <= {conversion_done_flag, 1'b0, converter_on, 1'b0, channel_select};
        end
    end
endmodule // sas_sequencer

// >>> hw/sas_pkg.sv
/*
  Constants for the 8-bit successive-approximation sequencer.
  Assumes a CPU-side register port with one-cycle read and write strobes.
*/
package sas_pkg;
    // -----------------------------------------------------------------
    // Register layout
    // -----------------------------------------------------------------
    localparam int CSR_DONE_BIT = 7;
    localparam int CSR_ON_BIT = 5;
    localparam int CSR_CH_LSB = 0;
    localparam int CSR_CH_W = 4;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] CSR_WRITE_MASK = 8'h2f;
    // -----------------------------------------------------------------
    // Timing, in converter clocks (one per two sys_clk)
    // -----------------------------------------------------------------
    localparam int CONV_CLOCKS = 12;
    localparam int APPROX_CLOCKS = 8;
    localparam int LOAD_CLOCKS = CONV_CLOCKS - APPROX_CLOCKS;
    localparam int CPU_PER_CONV_CLK = 2;
    localparam logic [3:0] LOAD_LAST = 4'(LOAD_CLOCKS - 1);
    localparam logic [3:0] APPROX_LAST = 4'(APPROX_CLOCKS - 1);
    // Trial code at the start of approximation: MSB set only
    localparam logic [7:0] TRIAL_START = 8'h80;
    // -----------------------------------------------------------------
    // States
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        SAS_OFF = 2'b00,
        SAS_LOAD = 2'b01,
        SAS_APPROX = 2'b11
    } sas_state_t;
endpackage

// >>> tb/sas_analog_model.sv
/* Analog side: pin levels, sample capacitor, comparator. Assumes full scale 8'hff. */
`timescale 1ns/1ps
module sas_analog_model (
    input wire logic sys_clk, // Clock
    input wire logic [3:0] mux_select, // Channel
    input wire logic sample_connect, // Switch
    input wire logic [7:0] trial_code, // Trial level
    input wire logic [15:0][7:0] level, // Pin levels
    output logic comp_high // Held charge at or above trial
);
    logic [7:0] held = 8'h00;
    always_ff @(posedge sys_clk) begin
        if (sample_connect) held <= level[mux_select];
    end
    assign comp_high = held >= trial_code;
endmodule // sas_analog_model

// >>> tb/sas_sequencer_sva.sv
/* Port checker for sas_sequencer. Assumes the default CHANNELS. */
`timescale 1ns/1ps
module sas_sequencer_chk import sas_pkg::*; (
    input wire logic sys_clk, // Clock
    input wire logic reset, // Reset
    input wire logic csr_wr, // Write
    input wire logic [7:0] csr_wdata, // Data
    input wire logic result_rd, // Read
    input wire logic [7:0] csr_rdata, // Status
    input wire logic [7:0] result_register, // Code
    input wire logic [3:0] mux_select, // Channel
    input wire logic sample_connect, // Switch
    input wire logic [7:0] trial_code, // Trial
    input wire logic converter_power // Power
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [5:0] cnt;
    logic seen;
    always_ff @(posedge sys_clk) begin
        cnt <= $rose(sample_connect) ? 6'h00 : cnt + 6'h01;
    end
    always_ff @(posedge sys_clk) begin
        seen <= !reset && !csr_wr && (seen || $rose(sample_connect));
    end
    sequence s_quiet; (!converter_power && !sample_connect && $stable(trial_code))[*4]; endsequence
    sequence s_wr_done; csr_wr ##1 (!csr_wr)[*2]; endsequence
    property p_period; $rose(sample_connect) && seen |-> cnt == 6'h17; endproperty
    a_period: assert property (p_period) else $error("period");
    property p_isolate;
        disable iff (reset || csr_wr)
        $fell(sample_connect) && !$past(csr_wr) |-> (!sample_connect)[*8];
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolate");
    property p_start; csr_wr && csr_wdata[5] |-> ##[1:4] sample_connect && converter_power; endproperty
    a_start: assert property (p_start) else $error("start");
    property p_off; csr_wr && !csr_wdata[5] |-> ##4 s_quiet; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_hold; !$stable(result_register) |-> !$past(sample_connect); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rd_clr;
        result_rd && sample_connect && $past(sample_connect) |-> ##2 !csr_rdata[7];
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read clear");
    property p_done;
        disable iff (reset || csr_wr || result_rd) $rose(sample_connect) && seen |-> ##[0:3] csr_rdata[7];
    endproperty
    a_done: assert property (p_done) else $error("done");
    property p_readback;
        s_wr_done |-> csr_rdata == ($past(csr_wdata, 2) & CSR_WRITE_MASK) && mux_select == $past(csr_wdata[3:0], 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback");
endmodule // sas_sequencer_chk
bind sas_sequencer sas_sequencer_chk i_sas_sequencer_chk (
    .sys_clk(sys_clk),
    .reset(reset),
    .csr_wr(csr_wr),
    .csr_wdata(csr_wdata),
    .result_rd(result_rd),
    .csr_rdata(csr_rdata),
    .result_register(result_register),
    .mux_select(mux_select),
    .sample_connect(sample_connect),
    .trial_code(trial_code),
    .converter_power(converter_power)
);

// >>> tb/sas_sequencer_bench.sv
/* Bench for sas_sequencer with the analog model. Assumes CHANNELS of 16. */
`timescale 1ns/1ps
module sas_sequencer_bench import sas_pkg::*;;
    logic sys_clk = 1'b0, reset = 1'b1, csr_wr = 1'b0, result_rd = 1'b0, comp_high;
    logic [7:0] csr_wdata = 8'h00, csr_rdata, result_register, trial_code;
    logic [3:0] mux_select;
    logic sample_connect, converter_power;
    logic [15:0][7:0] level = '0;
    int error_cnt = 0, tests_run = 0;
    initial forever #12.5 sys_clk = ~sys_clk;
    sas_sequencer i_sas_sequencer (
        .sys_clk(sys_clk),
        .reset(reset),
        .csr_wr(csr_wr),
        .csr_wdata(csr_wdata),
        .result_rd(result_rd),
        .comp_high(comp_high),
        .csr_rdata(csr_rdata),
        .result_register(result_register),
        .mux_select(mux_select),
        .sample_connect(sample_connect),
        .trial_code(trial_code),
        .converter_power(converter_power)
    );
    sas_analog_model i_sas_analog_model (
        .sys_clk(sys_clk),
        .mux_select(mux_select),
        .sample_connect(sample_connect),
        .trial_code(trial_code),
        .level(level),
        .comp_high(comp_high)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic rd, input logic [7:0] d);
        @(posedge sys_clk);
        csr_wr <= !rd;
        result_rd <= rd;
        csr_wdata <= d;
        @(posedge sys_clk);
        {csr_wr, result_rd} <= 2'b00;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic conv(input logic [3:0] ch, input logic [7:0] v, input logic go);
        level[ch] <= v;
        if (go) pulse(1'b0, {4'h2, ch});
        repeat (go ? 1 : 2) begin
            pulse(1'b1, 8'h00);
            for (int n = 0; n < 90 && csr_rdata[7] !== 1'b1; n++) @(posedge sys_clk);
            chk({7'h00, csr_rdata[7]}, 8'h01);
        end
        chk(result_register, v);
        pulse(1'b1, 8'h00);
        chk(csr_rdata, {4'h2, ch});
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk(csr_rdata, CSR_RESET);
        chk(result_register, RESULT_RESET);
        conv(4'h0, 8'h00, 1'b1);
        conv(4'hf, 8'hff, 1'b1);
        conv(4'h7, 8'h5a, 1'b1);
        conv(4'h8, 8'h5b, 1'b1);
        conv(4'h8, 8'ha5, 1'b0);
        level[1] <= 8'h33;
        pulse(1'b0, 8'h21);
        repeat (10) @(posedge sys_clk);
        chk(result_register, 8'ha5);
        conv(4'h2, 8'hc4, 1'b1);
        pulse(1'b0, 8'h0f);
        repeat (60) @(posedge sys_clk);
        chk({sample_connect, converter_power, csr_rdata[7:2]}, 8'h03);
        chk(result_register, 8'hc4);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        test_done;
    end
endmodule // sas_sequencer_bench
